// [common/rcf_regs.svh]
// register offsets, field positions and reset values of the reset cause flag block
`ifndef RCF_REGS_SVH
`define RCF_REGS_SVH

// byte offsets on the register bus
`define RCF_OFF_FLAGS  4'h0
`define RCF_OFF_STATUS 4'h4
`define RCF_OFF_MASK   4'h8

// field positions, shared by flags, status and mask
`define RCF_BIT_OVF 7
`define RCF_BIT_UNF 6
`define RCF_BIT_RSV 5
`define RCF_BIT_WDT 4
`define RCF_BIT_PIN 3
`define RCF_BIT_RI  2
`define RCF_BIT_POR 1
`define RCF_BIT_BOR 0

// power-on value of the flags and writable bits
`define RCF_FLAGS_POR   8'h1c
`define RCF_FLAGS_WMASK 8'hdf
`define RCF_STAT_WMASK  8'hdd

// idle level of the active-low reset pin
`define RCF_PIN_IDLE 1'b1

`endif

// [common/rcf_pkg.sv]
// types shared by the reset cause flag block
package rcf_pkg;

	typedef logic [7:0]  rcf_byte_t;
	typedef logic [31:0] rcf_word_t;

	// bus slave handshake states, one-hot
	typedef enum logic [1:0] {
		RCF_IDLE = 2'b01,
		RCF_ACK  = 2'b10
	} rcf_state_t;

endpackage

// [verilog/rcf_avmm_slave.sv]
// avalon-mm slave handshake with one wait cycle and registered read data
`timescale 1ns/1ps
`default_nettype none

module rcf_avmm_slave
	import rcf_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      nrst,
	input  wire logic      avs_read,
	input  wire logic      avs_write,
	input  wire rcf_word_t rd_word,
	output rcf_word_t      avs_readdata,
	output logic           avs_waitrequest,
	output logic           acc_rd,
	output logic           acc_wr
);

	rcf_state_t state_q;
	rcf_word_t  readdata_q;
	logic       req;

	assign req = avs_read | avs_write;

	// every request waits exactly one cycle, so read data can come from a flop
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= RCF_IDLE;
		end else begin
			case (state_q)
				RCF_IDLE: begin
					if (req) begin
						state_q <= RCF_ACK;
					end
				end
				RCF_ACK: begin
					state_q <= RCF_IDLE;
				end
				default: begin
					state_q <= RCF_IDLE;
				end
			endcase
		end
	end

	// snapshot taken in the wait cycle; on a status read the same bits are cleared on accept
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			readdata_q <= 32'h0000_0000;
		end else if (avs_read && state_q == RCF_IDLE) begin
			readdata_q <= rd_word;
		end
	end

	// handshake outputs are combinational
	assign avs_waitrequest = req && (state_q != RCF_ACK);
	assign acc_rd          = avs_read && (state_q == RCF_ACK);
	assign acc_wr          = avs_write && (state_q == RCF_ACK);
	assign avs_readdata    = readdata_q;

endmodule
`default_nettype wire

// [verilog/rcf_flags.sv]
// reset cause flag register with event status, mask and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "rcf_regs.svh"

// Operation
// - A readable register holds one flag each for power-on, brown-out, reset instruction, pin, watchdog, underflow and overflow.
// - Bit 7 is set by a stack overflow reset, is zero after power-on and stays set until firmware or a brown-out clears it.
// - Bit 6 is set by a stack underflow reset and reads zero until then or after firmware clears it.
// - Bit 4 is one after power-on, is cleared by a watchdog reset and may be written back to one.
// - Bits 3 and 2 are one after power-on, cleared by a pin reset and a reset instruction, and may be set again.
// - Bit 1 is cleared by every power-on reset and firmware sets it afterwards to spot the next one.
// - Bit 0 is cleared by a brown-out reset and firmware sets it after each power-on or brown-out.
module rcf_flags
	import rcf_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic [3:0] avs_address,
	input  wire logic       avs_read,
	input  wire logic       avs_write,
	input  wire rcf_word_t  avs_writedata,
	input  wire logic [3:0] avs_byteenable,
	output rcf_word_t       avs_readdata,
	output logic            avs_waitrequest,
	input  wire logic       external_reset_pin_n,
	input  wire logic       bor_event,
	input  wire logic       ri_event,
	input  wire logic       wdt_event,
	input  wire logic       stack_underflow_flag_event,
	input  wire logic       stack_overflow_flag_event,
	output rcf_byte_t       reset_cause_flags,
	output logic            irq
);

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// address compare, used by read mux and all write strobes
	function automatic logic rcf_hit(
		input logic [3:0] addr,
		input logic [3:0] off
	);
		rcf_hit = (addr == off);
	endfunction

	rcf_byte_t  flags_q;
	rcf_byte_t  flags_d;
	rcf_byte_t  status_q;
	rcf_byte_t  status_d;
	rcf_byte_t  mask_q;
	rcf_byte_t  mask_d;
	rcf_byte_t  ev_vec;
	rcf_byte_t  rd_clr;
	rcf_word_t  rd_word;
	logic       irq_q;
	logic       acc_rd;
	logic       acc_wr;
	logic       lane0_wr;
	logic       fw_flags_wr;
	logic       fw_mask_wr;
	logic       stat_rd;
	logic       pin_meta_q;
	logic       pin_sync_q;
	logic       pin_last_q;
	logic       pin_fall;

	// bus handshake and read data staging
	rcf_avmm_slave u_slave (
		.mclk            (mclk),
		.nrst            (nrst),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.rd_word         (rd_word),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.acc_rd          (acc_rd),
		.acc_wr          (acc_wr)
	);

	// the reset pin is asynchronous: two flops before anyone looks
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pin_meta_q <= `RCF_PIN_IDLE;
			pin_sync_q <= `RCF_PIN_IDLE;
			pin_last_q <= `RCF_PIN_IDLE;
		end else begin
			pin_meta_q <= external_reset_pin_n;
			pin_sync_q <= pin_meta_q;
			pin_last_q <= pin_sync_q;
		end
	end

	// a falling edge of the synchronised pin is one pin reset event
	assign pin_fall = pin_last_q & ~pin_sync_q;

	// write strobes; only byte lane 0 carries flag bits
	assign lane0_wr    = acc_wr && avs_byteenable[0];
	assign fw_flags_wr = lane0_wr && rcf_hit(avs_address, `RCF_OFF_FLAGS);
	assign fw_mask_wr  = lane0_wr && rcf_hit(avs_address, `RCF_OFF_MASK);
	assign stat_rd     = acc_rd && rcf_hit(avs_address, `RCF_OFF_STATUS);

	// read mux; unmapped offsets read as zero and ignore writes
	always_comb begin
		rd_word = 32'h0000_0000;
		if (rcf_hit(avs_address, `RCF_OFF_FLAGS)) begin
			rd_word[7:0] = flags_q;
		end else if (rcf_hit(avs_address, `RCF_OFF_STATUS)) begin
			rd_word[7:0] = status_q;
		end else if (rcf_hit(avs_address, `RCF_OFF_MASK)) begin
			rd_word[7:0] = mask_q;
		end
	end

	// flag next state: firmware first, hardware events after so they win
	always_comb begin
		flags_d = flags_q;
		if (fw_flags_wr) begin
			flags_d = avs_writedata[7:0] & `RCF_FLAGS_WMASK;
		end
		if (stack_overflow_flag_event) begin
			flags_d[`RCF_BIT_OVF] = 1'b1;
		end
		if (stack_underflow_flag_event) begin
			flags_d[`RCF_BIT_UNF] = 1'b1;
		end
		if (wdt_event) begin
			flags_d[`RCF_BIT_WDT] = 1'b0;
		end
		if (pin_fall) begin
			flags_d[`RCF_BIT_PIN] = 1'b0;
		end
		if (ri_event) begin
			flags_d[`RCF_BIT_RI] = 1'b0;
		end
		// brown-out reinitialises the register; power-on flag untouched
		if (bor_event) begin
			flags_d[`RCF_BIT_OVF] = 1'b0;
			flags_d[`RCF_BIT_UNF] = 1'b0;
			flags_d[`RCF_BIT_WDT] = 1'b1;
			flags_d[`RCF_BIT_PIN] = 1'b1;
			flags_d[`RCF_BIT_RI]  = 1'b1;
			flags_d[`RCF_BIT_BOR] = 1'b0;
		end
		flags_d[`RCF_BIT_RSV] = 1'b0;
	end

	// nrst is the power-on reset: power-on and brown-out flags both read zero
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			flags_q <= `RCF_FLAGS_POR;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign reset_cause_flags = flags_q;

	// one sticky status bit per event, same layout as the flags
	always_comb begin
		ev_vec                = 8'h00;
		ev_vec[`RCF_BIT_OVF]  = stack_overflow_flag_event;
		ev_vec[`RCF_BIT_UNF]  = stack_underflow_flag_event;
		ev_vec[`RCF_BIT_WDT]  = wdt_event;
		ev_vec[`RCF_BIT_PIN]  = pin_fall;
		ev_vec[`RCF_BIT_RI]   = ri_event;
		ev_vec[`RCF_BIT_BOR]  = bor_event;
	end

	// clear only what the reader saw, so a late event is not lost
	assign rd_clr   = stat_rd ? avs_readdata[7:0] : 8'h00;
	assign status_d = ((status_q & ~rd_clr) | ev_vec) & `RCF_STAT_WMASK;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			status_q <= 8'h00;
		end else begin
			status_q <= status_d;
		end
	end

	// mask register, reset to all masked
	assign mask_d = fw_mask_wr ? (avs_writedata[7:0] & `RCF_STAT_WMASK) : mask_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mask_q <= 8'h00;
		end else begin
			mask_q <= mask_d;
		end
	end

	// interrupt level from a flop, tracking status and mask with no lag
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_d & mask_d);
		end
	end

	assign irq = irq_q;

	// a read of the flags returns the value seen in the wait cycle
	sequence s_flags_read;
		avs_read && avs_waitrequest && rcf_hit(avs_address, `RCF_OFF_FLAGS)
		##1 avs_read && !avs_waitrequest;
	endsequence

	AST_FLAGS_READBACK: assert property (
		s_flags_read |-> avs_readdata == {24'h000000, $past(flags_q)}
	) else $error("flags read returned wrong value");

	AST_OVF_SET: assert property (
		stack_overflow_flag_event && !bor_event |=> flags_q[`RCF_BIT_OVF]
	) else $error("overflow event did not set flag");

	// overflow flag only rises by its own event or a firmware write
	AST_OVF_STICKY: assert property (
		flags_q[`RCF_BIT_OVF] && !$past(fw_flags_wr) && !$past(bor_event)
		|-> $past(flags_q[`RCF_BIT_OVF]) || $past(stack_overflow_flag_event)
	) else $error("overflow flag changed without cause");

	AST_UNF_SET: assert property (
		stack_underflow_flag_event && !bor_event |=> flags_q[`RCF_BIT_UNF]
	) else $error("underflow event did not set flag");

	AST_WDT_CLR: assert property (
		wdt_event && !bor_event |=> !flags_q[`RCF_BIT_WDT]
	) else $error("watchdog event did not clear flag");

	// pin held low after being high reaches the flag within a bounded time
	sequence s_pin_drop;
		external_reset_pin_n ##1 !external_reset_pin_n [*3];
	endsequence

	AST_PIN_CLR: assert property (
		s_pin_drop ##0 !bor_event [*2] |-> ##[0:2] !flags_q[`RCF_BIT_PIN]
	) else $error("pin reset did not clear flag");

	AST_RI_CLR: assert property (
		ri_event && !bor_event |=> !flags_q[`RCF_BIT_RI]
	) else $error("reset instruction did not clear flag");

	// power-on flag only rises when firmware writes a one
	AST_POR_ONLY_FW: assert property (
		$rose(flags_q[`RCF_BIT_POR])
		|-> $past(fw_flags_wr) && $past(avs_writedata[`RCF_BIT_POR])
	) else $error("power-on flag rose without a write");

	AST_BOR_INIT: assert property (
		bor_event |=> !flags_q[`RCF_BIT_BOR] && !flags_q[`RCF_BIT_OVF]
		&& flags_q[`RCF_BIT_WDT] && flags_q[`RCF_BIT_PIN] && flags_q[`RCF_BIT_RI]
	) else $error("brown-out did not initialise flags");

	// firmware clearing overflow in the same cycle as the event loses
	AST_HW_PRIORITY: assert property (
		fw_flags_wr && !avs_writedata[`RCF_BIT_OVF] && stack_overflow_flag_event && !bor_event
		|=> flags_q[`RCF_BIT_OVF]
	) else $error("firmware write beat hardware event");

	AST_RSV_ZERO: assert property (
		!flags_q[`RCF_BIT_RSV] && !status_q[`RCF_BIT_RSV]
	) else $error("reserved bit read as one");

	// plain write with no event lands exactly
	AST_FW_WRITE: assert property (
		fw_flags_wr && ev_vec == 8'h00
		|=> flags_q == (($past(avs_writedata[7:0])) & `RCF_FLAGS_WMASK)
	) else $error("flag write did not land");

	// an event during a status read survives the clear
	AST_STATUS_SET_WINS: assert property (
		stat_rd && ev_vec != 8'h00 |=> (status_q & $past(ev_vec)) == $past(ev_vec)
	) else $error("event lost on status read");

	AST_IRQ_LEVEL: assert property (
		irq == |(status_q & mask_q)
	) else $error("interrupt level does not follow status");

	// every request gets accepted in the second cycle
	AST_ONE_WAIT: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest
	) else $error("request not accepted after one wait cycle");

	// a read of the status register, from wait cycle to accept
	sequence s_status_read;
		avs_read && avs_waitrequest && rcf_hit(avs_address, `RCF_OFF_STATUS)
		##1 avs_read && !avs_waitrequest;
	endsequence

	// a quiet status read leaves none of the returned bits behind
	AST_STATUS_READ_CLR: assert property (
		s_status_read ##0 (ev_vec == 8'h00) |=> (status_q & $past(avs_readdata[7:0])) == 8'h00
	) else $error("status read did not clear returned bits");

	// every event lands in its sticky status bit, read or no read
	AST_STATUS_SET: assert property (
		ev_vec != 8'h00 |=> (status_q & $past(ev_vec)) == $past(ev_vec)
	) else $error("event did not set status");

	// stack flags hold until firmware or brown-out moves them
	AST_OVF_HOLD: assert property (
		flags_q[`RCF_BIT_OVF] && !fw_flags_wr && !bor_event |=> flags_q[`RCF_BIT_OVF]
	) else $error("overflow flag dropped on its own");

	AST_UNF_HOLD: assert property (
		flags_q[`RCF_BIT_UNF] && !fw_flags_wr && !bor_event |=> flags_q[`RCF_BIT_UNF]
	) else $error("underflow flag dropped on its own");

	AST_UNF_NO_RISE: assert property (
		$rose(flags_q[`RCF_BIT_UNF]) |-> $past(stack_underflow_flag_event) || $past(fw_flags_wr)
	) else $error("underflow flag rose without cause");

	// cleared-by-event flags come back only through firmware or a brown-out
	AST_CLR_FLAGS_NO_RISE: assert property (
		$rose(flags_q[`RCF_BIT_PIN]) || $rose(flags_q[`RCF_BIT_RI])
		|-> $past(fw_flags_wr) || $past(bor_event)
	) else $error("pin or instruction flag rose without cause");

	AST_WDT_NO_RISE: assert property (
		$rose(flags_q[`RCF_BIT_WDT]) |-> $past(fw_flags_wr) || $past(bor_event)
	) else $error("watchdog flag rose without cause");

	// only a real power-on or a firmware write clears the power-on flag; brown-out keeps it
	AST_BOR_KEEPS_POR: assert property (
		bor_event && !fw_flags_wr |=> flags_q[`RCF_BIT_POR] == $past(flags_q[`RCF_BIT_POR])
	) else $error("brown-out changed the power-on flag");

	// mask writes land with the unused bits forced low
	AST_MASK_WRITE: assert property (
		fw_mask_wr |=> mask_q == ($past(avs_writedata[7:0]) & `RCF_STAT_WMASK)
	) else $error("mask write did not land");

	// upper read data lanes never carry anything
	AST_READ_UPPER_ZERO: assert property (
		avs_readdata[31:8] == 24'h000000
	) else $error("upper read data lanes not zero");

	// a write on the wrong lane or offset must not touch the flags or mask register
	AST_IGNORED_WRITE: assert property (
		acc_wr && !fw_flags_wr && !fw_mask_wr && ev_vec == 8'h00 |=> $stable(flags_q) && $stable(mask_q)
	) else $error("ignored write changed a register");

endmodule
`default_nettype wire

// [dv/tb_rcf_flags.sv]
// self-checking bench of the reset cause flag block
`timescale 1ns/1ps
`default_nettype none
`include "rcf_regs.svh"
module tb_rcf_flags import rcf_pkg::*;;
	logic       mclk           = 1'b0;
	logic       nrst           = 1'b0;
	logic [3:0] avs_address    = 4'h0;
	logic       avs_read       = 1'b0;
	logic       avs_write      = 1'b0;
	rcf_word_t  avs_writedata  = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	rcf_word_t  avs_readdata;
	logic       avs_waitrequest;
	logic       pin_n          = 1'b1;
	logic [4:0] evs            = 5'h0;
	rcf_byte_t  flags;
	logic       irq;
	rcf_word_t  rd;
	int         mismatches     = 0;
	int         checked        = 0;
	// event order: ovf, unf, wdt, ri, bor, pin (bit 5 drives the pin low)
	logic [5:0] ev_t [6] = '{6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h20};
	rcf_byte_t  fl_t [6] = '{8'h9f, 8'h5f, 8'h0f, 8'h1b, 8'h1e, 8'h17};
	rcf_byte_t  st_t [6] = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h01, 8'h08};

	rcf_flags u_dut (
		.mclk                 (mclk),
		.nrst                 (nrst),
		.avs_address          (avs_address),
		.avs_read             (avs_read),
		.avs_write            (avs_write),
		.avs_writedata        (avs_writedata),
		.avs_byteenable       (avs_byteenable),
		.avs_readdata         (avs_readdata),
		.avs_waitrequest      (avs_waitrequest),
		.external_reset_pin_n (pin_n),
		.bor_event            (evs[0]),
		.ri_event             (evs[1]),
		.wdt_event            (evs[2]),
		.stack_underflow_flag_event         (evs[3]),
		.stack_overflow_flag_event         (evs[4]),
		.reset_cause_flags    (flags),
		.irq                  (irq)
	);

	// 40 MHz
	initial begin
		forever #12.5 mclk = ~mclk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one avalon access; ev pulses in the accepted cycle so it races the write
	// the loop drops ev at every later edge, so nothing assigns it twice per step
	task automatic bus(input logic wr, input logic [3:0] a, input rcf_byte_t d, input logic [3:0] be,
		input logic [4:0] ev);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address    <= a;
		avs_writedata  <= {24'h0, d};
		avs_byteenable <= be;
		avs_write      <= wr;
		avs_read       <= ~wr;
		do begin
			@(posedge mclk);
			evs <= (n == 0) ? ev : 5'h0;
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 20) begin
			mismatches++;
			$display("ERROR waitrequest expected 0 seen %b", avs_waitrequest);
		end
	endtask

	task automatic rd_chk(input logic [3:0] a, input rcf_byte_t exp, input string what);
		bus(1'b0, a, 8'h00, 4'h0, 5'h0);
		chk(what, {24'h0, exp}, rd);
	endtask

	// pin low for several edges must still count once
	task automatic pulse(input logic [5:0] ev);
		@(posedge mclk);
		evs   <= ev[4:0];
		pin_n <= ~ev[5];
		@(posedge mclk);
		evs <= 5'h0;
		repeat (4) @(posedge mclk);
		pin_n <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	task automatic t_reset;
		rd_chk(`RCF_OFF_FLAGS, 8'h1c, "flags");
		chk("flags_port", 32'h1c, {24'h0, flags});
		rd_chk(`RCF_OFF_MASK, 8'h00, "mask");
		rd_chk(4'hc, 8'h00, "unmapped");
		chk("irq", 32'h0, {31'h0, irq});
		$display("test reset done");
	endtask

	task automatic t_write;
		bus(1'b1, `RCF_OFF_FLAGS, 8'hff, 4'h1, 5'h0);
		rd_chk(`RCF_OFF_FLAGS, 8'hdf, "flags_wr");
		bus(1'b1, `RCF_OFF_FLAGS, 8'h00, 4'he, 5'h0);
		bus(1'b1, 4'hc, 8'h00, 4'h1, 5'h0);
		rd_chk(`RCF_OFF_FLAGS, 8'hdf, "flags_ignored");
		$display("test write done");
	endtask

	task automatic t_events;
		bus(1'b1, `RCF_OFF_MASK, 8'hdd, 4'h1, 5'h0);
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, `RCF_OFF_FLAGS, 8'h1f, 4'h1, 5'h0);
			pulse(ev_t[i]);
			chk("flags_ev", {24'h0, fl_t[i]}, {24'h0, flags});
			chk("irq_set", 32'h1, {31'h0, irq});
			rd_chk(`RCF_OFF_STATUS, st_t[i], "status");
			#1;
			chk("irq_clr", 32'h0, {31'h0, irq});
		end
		// masked event keeps its status bit but stays quiet
		bus(1'b1, `RCF_OFF_MASK, 8'h00, 4'h1, 5'h0);
		pulse(6'h10);
		chk("irq_masked", 32'h0, {31'h0, irq});
		rd_chk(`RCF_OFF_STATUS, 8'h80, "status_masked");
		$display("test events done");
	endtask

	task automatic t_prio;
		bus(1'b1, `RCF_OFF_FLAGS, 8'h00, 4'h1, 5'h10);
		rd_chk(`RCF_OFF_FLAGS, 8'h80, "flags_ovf_wins");
		bus(1'b1, `RCF_OFF_FLAGS, 8'hff, 4'h1, 5'h04);
		rd_chk(`RCF_OFF_FLAGS, 8'hcf, "flags_wdt_wins");
		// an event at the accept edge of a status read stays pending
		bus(1'b0, `RCF_OFF_STATUS, 8'h00, 4'h0, 5'h08);
		chk("status_race", 32'h90, rd);
		rd_chk(`RCF_OFF_STATUS, 8'h40, "status_kept");
		$display("test priority done");
	endtask

	task automatic t_por;
		bus(1'b1, `RCF_OFF_FLAGS, 8'hff, 4'h1, 5'h08);
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		#1;
		chk("flags_por", 32'h1c, {24'h0, flags});
		rd_chk(`RCF_OFF_STATUS, 8'h00, "status_por");
		$display("test second power-on done");
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		t_reset;
		t_write;
		t_events;
		t_prio;
		t_por;
		test_done;
	end

	// the whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		$display("ERROR watchdog expected finish seen hang");
		test_done;
	end
endmodule
`default_nettype wire
